// File: verilog/pmtrp_pkg.sv
package pmtrp_pkg;
  // ******************************
  // Clock rates and MII clock divider
  // ******************************
  localparam int CLK_HZ = 40_000_000;
  localparam int MII_HZ_100 = 25_000_000;
  localparam int MII_HZ_10 = 2_500_000;
  // Half periods round down, never below one cycle
  localparam int HALF_100_I = CLK_HZ / (2 * MII_HZ_100);
  localparam int HALF_10_I = CLK_HZ / (2 * MII_HZ_10);
  localparam logic [3:0] HALF_100 =
    (HALF_100_I < 1) ? 4'h1 : 4'(HALF_100_I);
  localparam logic [3:0] HALF_10 =
    (HALF_10_I < 1) ? 4'h1 : 4'(HALF_10_I);

  // ******************************
  // Register map
  // ******************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CFG = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam int CTRL_LB_BIT = 14;
  localparam int CTRL_AN_BIT = 12;
  localparam int CTRL_DUP_BIT = 8;
  localparam int CFG_ECHO_DIS_BIT = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_1000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int ST_SPD = 0;
  localparam int ST_FDX = 1;
  localparam int ST_CRS = 2;
  localparam int ST_COL = 3;
  localparam int ST_TLB = 4;
  localparam int ST_ECHO = 5;

  // ******************************
  // Code groups and nibbles
  // ******************************
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_SFD = 4'hD;
  localparam logic [3:0] NIB_ERR = 4'h5;
  localparam logic [10:0] SCR_SEED = 11'h7FF;

  typedef enum logic [3:0] {
    T_IDLE = 4'h1, T_K = 4'h2, T_DATA = 4'h4, T_R = 4'h8
  } pmtrp_tx_state_t;
  typedef enum logic [3:0] {
    R_IDLE = 4'h1, R_K = 4'h2, R_DATA = 4'h4, R_END = 4'h8
  } pmtrp_rx_state_t;
endpackage

// File: verilog/pmtrp_scr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pmtrp_scr_if;
  logic step;
  logic load;
  logic [4:0] din;
  logic [4:0] dout;
  modport scr (input step, input load, input din, output dout);
  modport user (output step, output load, output din, input dout);
endinterface
`default_nettype wire

// File: verilog/pmtrp_scrambler.sv
`timescale 1ns/100ps
`default_nettype none
module pmtrp_scrambler
  import pmtrp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pmtrp_scr_if.scr s
);
  typedef struct packed {
    logic [10:0] lfsr;
  } pmtrp_scr_st_t;

  pmtrp_scr_st_t st_ff;
  pmtrp_scr_st_t nxt_st;

  // ******************************
  // Side-stream key, five bits per code group
  // ******************************
  // Load takes the key from an idle group, which is all ones unscrambled
  always_comb begin
    logic [10:0] k;
    logic [10:0] ld;
    logic [4:0] key;
    logic b;
    k = st_ff.lfsr;
    ld = st_ff.lfsr;
    key = 5'h00;
    b = 1'b0;
    for (int i = 0; i < 5; i++) begin
      b = k[10] ^ k[8];
      key[4 - i] = b;
      k = {k[9:0], b};
      ld = {ld[9:0], ~s.din[4 - i]};
    end
    s.dout = s.din ^ key;
    nxt_st = st_ff;
    if (s.load) begin
      nxt_st.lfsr = ld;
    end else if (s.step) begin
      nxt_st.lfsr = k;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.lfsr <= SCR_SEED;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// File: verilog/pmtrp_path.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pmtrp_path
  import pmtrp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_speed_100,
  input wire logic link_full_duplex,
  output logic tx_clk,
  output logic rx_clk,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic [4:0] twisted_pair_tx_out,
  input wire logic line_rx_clk,
  input wire logic [4:0] line_rx_code
);
  typedef struct packed {
    logic [3:0] txd1;
    logic [3:0] txd2;
    logic ten1;
    logic ten2;
    logic ter1;
    logic ter2;
    logic lck1;
    logic lck2;
    logic lck3;
    logic [4:0] lc1;
    logic [4:0] lc2;
    logic [3:0] cnt;
    logic mclk;
    logic spd;
    logic rise1;
    logic rise2;
    pmtrp_tx_state_t tst;
    logic [4:0] raw;
    logic upd;
    logic [4:0] tout;
    pmtrp_rx_state_t rst;
    logic [3:0] prev;
    logic pv;
    logic pdv;
    logic per;
    logic [3:0] pd;
    logic [3:0] rxd;
    logic rxdv;
    logic rxer;
    logic lb;
    logic dup;
    logic an;
    logic echo_dis;
    logic [31:0] prdata;
    logic slverr;
  } pmtrp_st_t;

  pmtrp_st_t st_ff;
  pmtrp_st_t nxt_st;
  logic full;
  logic half;
  logic tlb;
  logic echo;
  logic tick;
  logic evt;
  logic tx_act;
  logic line_act;
  logic rx_act;
  logic [4:0] rsym;
  logic [4:0] rdec;

  // ******************************
  // 4B/5B coding
  // ******************************
  function automatic logic [4:0] enc4(input logic [3:0] n);
    logic [4:0] c;
    unique case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction

  // Decode by reverse search; bit 4 says the group was a data group
  function automatic logic [4:0] dec5(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc4(4'(i)) == c) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // ******************************
  // Scramblers
  // ******************************
  pmtrp_scr_if tsi ();
  pmtrp_scr_if rsi ();

  pmtrp_scrambler u_tx_scr (
    .pclk(pclk),
    .presetn(presetn),
    .s(tsi.scr)
  );

  pmtrp_scrambler u_rx_scr (
    .pclk(pclk),
    .presetn(presetn),
    .s(rsi.scr)
  );

  assign tsi.step = st_ff.upd & st_ff.spd;
  assign tsi.load = 1'b0;
  assign tsi.din = st_ff.raw;
  // Receive side relocks on every group other than J seen in R_IDLE, so noise between frames heals
  assign rsi.din = st_ff.lc2;
  assign rsi.load = evt & st_ff.spd & (st_ff.rst == R_IDLE) &
    (rsi.dout != CG_J);
  assign rsi.step = evt & st_ff.spd & ~rsi.load;
  assign rsym = rsi.dout;
  assign rdec = dec5(rsym);

  // ******************************
  // Modes and unclocked status
  // ******************************
  assign full = st_ff.an ? link_full_duplex : st_ff.dup;
  assign half = ~full;
  assign tlb = st_ff.lb & st_ff.dup & ~st_ff.an;
  assign echo = ~st_ff.spd & half & ~st_ff.echo_dis & ~tlb;
  assign tick = st_ff.rise2;
  assign evt = st_ff.lck2 & ~st_ff.lck3 & ~tlb;
  assign tx_act = st_ff.ten2 | (st_ff.tst != T_IDLE);
  assign line_act = st_ff.rst != R_IDLE;
  assign rx_act = line_act | (tlb & st_ff.ten2);
  assign crs = rx_act | (half & tx_act);
  assign col = half & tx_act & line_act;

  assign tx_clk = st_ff.mclk;
  assign rx_clk = st_ff.mclk;
  assign rxd = st_ff.rxd;
  assign rx_dv = st_ff.rxdv;
  assign rx_er = st_ff.rxer;
  assign twisted_pair_tx_out = st_ff.tout;
  assign prdata = st_ff.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & st_ff.slverr;

  always_comb begin
    logic [3:0] hs;
    logic fall;
    logic lp;
    logic [3:0] lp_d;
    logic lp_dv;
    logic lp_er;
    hs = st_ff.spd ? HALF_100 : HALF_10;
    fall = 1'b0;
    lp = 1'b0;
    lp_d = 4'h0;
    lp_dv = 1'b0;
    lp_er = 1'b0;
    nxt_st = st_ff;

    // ******************************
    // Input synchronisers
    // ******************************
    nxt_st.txd1 = txd;
    nxt_st.txd2 = st_ff.txd1;
    nxt_st.ten1 = tx_en;
    nxt_st.ten2 = st_ff.ten1;
    nxt_st.ter1 = tx_er;
    nxt_st.ter2 = st_ff.ter1;
    nxt_st.lck1 = line_rx_clk;
    nxt_st.lck2 = st_ff.lck1;
    nxt_st.lck3 = st_ff.lck2;
    nxt_st.lc1 = line_rx_code;
    nxt_st.lc2 = st_ff.lc1;

    // ******************************
    // MII clock generation
    // ******************************
    // Speed is taken only at a clock phase boundary: no runt phases
    nxt_st.rise1 = 1'b0;
    nxt_st.rise2 = st_ff.rise1;
    if (st_ff.cnt >= hs - 4'h1) begin
      nxt_st.cnt = 4'h0;
      nxt_st.mclk = ~st_ff.mclk;
      nxt_st.spd = link_speed_100;
      nxt_st.rise1 = ~st_ff.mclk;
      fall = st_ff.mclk;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end

    // ******************************
    // Transmit encoder
    // ******************************
    // Sync delay is two cycles, so the data before the rise is read here
    nxt_st.upd = tick;
    if (!st_ff.spd) begin
      nxt_st.tst = T_IDLE;
    end
    if (tick) begin
      if (!st_ff.spd) begin
        nxt_st.raw = {st_ff.ten2, st_ff.txd2};
      end else begin
        unique case (st_ff.tst)
          T_IDLE: begin
            if (st_ff.ten2) begin
              nxt_st.raw = CG_J;
              nxt_st.tst = T_K;
            end else begin
              nxt_st.raw = CG_IDLE;
            end
          end
          T_K: begin
            nxt_st.raw = CG_K;
            nxt_st.tst = T_DATA;
          end
          T_DATA: begin
            if (st_ff.ten2) begin
              nxt_st.raw = st_ff.ter2 ? CG_H : enc4(st_ff.txd2);
            end else begin
              nxt_st.raw = CG_T;
              nxt_st.tst = T_R;
            end
          end
          T_R: begin
            nxt_st.raw = CG_R;
            nxt_st.tst = T_IDLE;
          end
        endcase
      end
    end
    if (st_ff.upd) begin
      if (tlb) begin
        nxt_st.tout = 5'h00;
      end else begin
        nxt_st.tout = st_ff.spd ? tsi.dout : st_ff.raw;
      end
    end

    // ******************************
    // Line receive
    // ******************************
    if (evt && st_ff.spd) begin
      unique case (st_ff.rst)
        R_IDLE: begin
          if (rsym == CG_J) begin
            nxt_st.rst = R_K;
            lp = 1'b1;
            lp_d = NIB_PRE;
            lp_dv = 1'b1;
          end
        end
        R_K: begin
          nxt_st.rst = R_DATA;
          lp = 1'b1;
          lp_dv = 1'b1;
          lp_d = NIB_PRE;
          if (rsym != CG_K) begin
            lp_d = NIB_ERR;
            lp_er = 1'b1;
          end
        end
        R_DATA: begin
          lp = 1'b1;
          if (rsym == CG_T || rsym == CG_IDLE) begin
            nxt_st.rst = (rsym == CG_T) ? R_END : R_IDLE;
          end else if (rdec[4]) begin
            lp_d = rdec[3:0];
            lp_dv = 1'b1;
          end else begin
            lp_d = NIB_ERR;
            lp_dv = 1'b1;
            lp_er = 1'b1;
          end
        end
        R_END: begin
          nxt_st.rst = R_IDLE;
        end
      endcase
    end else if (evt) begin
      // One nibble of delay lets the SFD's first nibble open the frame
      unique case (st_ff.rst)
        R_IDLE: begin
          if (st_ff.lc2[4]) begin
            nxt_st.rst = R_K;
          end
        end
        R_K: begin
          if (!st_ff.lc2[4]) begin
            nxt_st.rst = R_IDLE;
          end else if (st_ff.prev == NIB_PRE &&
                       st_ff.lc2[3:0] == NIB_SFD) begin
            nxt_st.rst = R_DATA;
            lp = 1'b1;
            lp_d = st_ff.prev;
            lp_dv = 1'b1;
          end
        end
        R_DATA: begin
          lp = 1'b1;
          lp_d = st_ff.prev;
          lp_dv = 1'b1;
          if (!st_ff.lc2[4]) begin
            nxt_st.rst = R_END;
          end
        end
        R_END: begin
          lp = 1'b1;
          nxt_st.rst = R_IDLE;
        end
      endcase
      nxt_st.prev = st_ff.lc2[3:0];
    end

    // ******************************
    // Receive nibble hand-off to the MII
    // ******************************
    // A single holding slot: a nibble not shown before the next arrives
    // is overwritten, so line and MII rates must match
    if (fall && st_ff.pv) begin
      nxt_st.pv = 1'b0;
      nxt_st.rxd = st_ff.pd;
      nxt_st.rxdv = st_ff.pdv;
      nxt_st.rxer = st_ff.per;
    end
    if (tick && (tlb || echo)) begin
      nxt_st.pv = 1'b1;
      nxt_st.pd = st_ff.txd2;
      nxt_st.pdv = st_ff.ten2;
      nxt_st.per = st_ff.ter2;
    end else if (lp && !echo) begin
      nxt_st.pv = 1'b1;
      nxt_st.pd = lp_d;
      nxt_st.pdv = lp_dv;
      nxt_st.per = lp_er;
    end

    // ******************************
    // APB registers
    // ******************************
    if (psel && !penable) begin
      nxt_st.slverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CTRL: begin
          nxt_st.prdata[CTRL_LB_BIT] = st_ff.lb;
          nxt_st.prdata[CTRL_AN_BIT] = st_ff.an;
          nxt_st.prdata[CTRL_DUP_BIT] = st_ff.dup;
        end
        REG_CFG: nxt_st.prdata[CFG_ECHO_DIS_BIT] = st_ff.echo_dis;
        REG_STAT: begin
          nxt_st.prdata[ST_SPD] = st_ff.spd;
          nxt_st.prdata[ST_FDX] = full;
          nxt_st.prdata[ST_CRS] = crs;
          nxt_st.prdata[ST_COL] = col;
          nxt_st.prdata[ST_TLB] = tlb;
          nxt_st.prdata[ST_ECHO] = echo;
        end
        default: nxt_st.slverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && !st_ff.slverr) begin
      if (paddr == REG_CTRL) begin
        nxt_st.lb = pwdata[CTRL_LB_BIT];
        nxt_st.an = pwdata[CTRL_AN_BIT];
        nxt_st.dup = pwdata[CTRL_DUP_BIT];
      end else if (paddr == REG_CFG) begin
        nxt_st.echo_dis = pwdata[CFG_ECHO_DIS_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.tst <= T_IDLE;
      st_ff.rst <= R_IDLE;
      st_ff.raw <= CG_IDLE;
      st_ff.an <= CTRL_RST[CTRL_AN_BIT];
      st_ff.dup <= CTRL_RST[CTRL_DUP_BIT];
      st_ff.lb <= CTRL_RST[CTRL_LB_BIT];
      st_ff.echo_dis <= CFG_RST[CFG_ECHO_DIS_BIT];
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_clk_slow_rate: assert property (
    $rose(st_ff.mclk) && !st_ff.spd |-> st_ff.mclk [*8] ##1 !st_ff.mclk)
    else $error("10M MII clock high phase wrong");
  a_clk_fast_rate: assert property (
    $rose(st_ff.mclk) && st_ff.spd |=> !st_ff.mclk ##1 st_ff.mclk)
    else $error("100M MII clock period wrong");
  a_tx_start_jk: assert property (
    tick && st_ff.spd && st_ff.tst == T_IDLE && st_ff.ten2 |=>
    st_ff.raw == CG_J ##[1:40] st_ff.raw == CG_K)
    else $error("J K pair not sent");
  a_tx_end_tr: assert property (
    tick && st_ff.spd && st_ff.tst == T_DATA && !st_ff.ten2 |=>
    st_ff.raw == CG_T ##[1:40] st_ff.raw == CG_R)
    else $error("T R pair not sent");
  a_tx_err_group: assert property (
    tick && st_ff.spd && st_ff.tst == T_DATA && st_ff.ten2 &&
    st_ff.ter2 |=> st_ff.raw == CG_H)
    else $error("Error group not sent");
  a_tx_idle_fill: assert property (
    tick && st_ff.spd && st_ff.tst == T_IDLE && !st_ff.ten2 |=>
    st_ff.raw == CG_IDLE)
    else $error("Idle group not sent");
  a_rx_pre_sub: assert property (
    evt && st_ff.spd && st_ff.rst == R_IDLE && rsym == CG_J && !echo
    |=> st_ff.pv && st_ff.pdv && st_ff.pd == NIB_PRE)
    else $error("J not replaced by preamble");
  a_rx_bad_sym: assert property (
    evt && st_ff.spd && st_ff.rst == R_DATA && !rdec[4] &&
    rsym != CG_T && rsym != CG_IDLE && !echo
    |=> st_ff.per && st_ff.pd == NIB_ERR)
    else $error("Invalid symbol not flagged");
  a_rx_sfd_open: assert property (
    evt && !st_ff.spd && st_ff.rst == R_K && st_ff.lc2[4] &&
    st_ff.prev == NIB_PRE && st_ff.lc2[3:0] == NIB_SFD && !echo
    |=> st_ff.pdv && st_ff.pd == NIB_PRE && st_ff.rst == R_DATA)
    else $error("SFD did not open frame");
  a_col_full_none: assert property (full |-> !col)
    else $error("Collision in full duplex");
  a_col_held: assert property (
    col && $stable(tx_act) && $stable(line_act) && $stable(half) |-> $past(col))
    else $error("Collision dropped while active");
  a_crs_rx_line: assert property (line_act |-> crs)
    else $error("No carrier on receive");
  a_crs_full_tx: assert property (full && !rx_act |-> !crs)
    else $error("Carrier on full duplex transmit");
  a_tlb_line_off: assert property (
    tlb && st_ff.upd |=> st_ff.tout == 5'h00)
    else $error("Line driven in test loopback");

  c_frame_fast: cover property (st_ff.spd && st_ff.rst == R_DATA);
  c_collision: cover property ($rose(col));
  c_echo_data: cover property (echo && tick && st_ff.ten2);
  c_test_loop: cover property (tlb && tick && st_ff.ten2);
endmodule
`default_nettype wire

// File: verif/pmtrp_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
// ******
// MAC side of the transmit path
// ******
module pmtrp_mac_model (
  input wire logic tx_clk,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er
);
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  // Idle data lines flip each cycle so a stale nibble never looks valid
  task automatic send(input logic [5:0] v);
    @(posedge tx_clk);
    tx_er <= v[5];
    tx_en <= v[4];
    txd <= v[4] ? v[3:0] : ~txd;
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ******
// Bench top
// ******
module testbench
  import pmtrp_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic spd, fdx, tx_clk, rx_clk, tx_en, tx_er, rx_dv, rx_er, crs, col;
  logic [3:0] txd, rxd;
  logic [4:0] tp_out, lcode, lastr, p;
  logic lclk;
  logic [10:0] h;
  logic [4:0] rq[$];
  logic [4:0] tq[$];
  int err_total, n_checks, crs_n, col_n, b, c0, i;

  pmtrp_path dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_speed_100(spd), .link_full_duplex(fdx), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .rxd(rxd),
    .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .col(col),
    .twisted_pair_tx_out(tp_out), .line_rx_clk(lclk),
    .line_rx_code(lcode));
  pmtrp_mac_model mac (.tx_clk(tx_clk), .txd(txd), .tx_en(tx_en),
    .tx_er(tx_er));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Receive log keeps only changes while valid, so repeats collapse
  always @(posedge pclk) begin
    crs_n <= crs_n + int'(crs === 1'b1);
    col_n <= col_n + int'(col === 1'b1);
    if (rx_dv === 1'b1 && {rx_er, rxd} !== lastr)
      rq.push_back({rx_er, rxd});
    lastr <= (rx_dv === 1'b1) ? {rx_er, rxd} : 5'h1f;
  end
  always @(posedge tx_clk)
    tq.push_back(tp_out);

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Key bits follow k(n) = k(n-11) ^ k(n-9); learnt from idle, no seed
  function automatic logic [4:0] ks(input logic [4:0] o, input logic lrn);
    logic [4:0] v;
    logic k;
    for (int j = 4; j >= 0; j--) begin
      k = lrn ? o[j] : h[10] ^ h[8];
      h = {h[9:0], k};
      v[j] = k;
    end
    return v;
  endfunction

  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic f10;
    b = rq.size();
    c0 = crs_n;
    mac.send(6'h15);
    mac.send(6'h1d);
    mac.send(6'h1a);
    repeat (4) mac.send(6'h00);
  endtask

  task automatic rxchk(input logic [4:0] x[$]);
    chk(32'(rq.size() - b), 32'(x.size()));
    foreach (x[j])
      chk(32'(rq[b + j]), 32'(x[j]));
  endtask

  task automatic txchk(input logic [4:0] x[$]);
    foreach (x[j]) begin
      chk(32'(tq[i] ^ ks(5'h00, 1'b0)), 32'(x[j]));
      i++;
    end
  endtask

  task automatic per(input int x);
    realtime t;
    repeat (3) @(posedge tx_clk);
    t = $realtime;
    @(posedge tx_clk);
    chk(32'(int'($realtime - t)), 32'(x));
  endtask

  // Line clock only runs inside a burst, its edges always 7 ns after a pclk rise
  task automatic line(input logic [4:0] q[$]);
    #7;
    foreach (q[j]) begin
      lcode = q[j] ^ ks(5'h00, 1'b0);
      #100 lclk = 1'b1;
      #100 lclk = 1'b0;
    end
    lcode = ~lcode;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    end_sim();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    spd = 1'b0;
    fdx = 1'b0;
    lclk = 1'b0;
    lcode = 5'h00;
    lastr = 5'h1f;
    h = 11'h7ff;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(REG_CTRL, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_1000);
    apb(REG_CFG, 1'b0, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    apb(12'h00c, 1'b1, 32'h0000_0100);
    chk(32'(e), 32'h0000_0001);
    $display("test registers done");
    per(50 * HALF_10);
    apb(REG_CFG, 1'b1, 32'h0000_0100);
    f10();
    chk(32'(rq.size() - b), 32'h0000_0000);
    apb(REG_CFG, 1'b1, 32'h0000_0000);
    f10();
    rxchk({5'h05, 5'h0d, 5'h0a});
    chk(32'(crs_n > c0), 32'h0000_0001);
    fdx <= 1'b1;
    f10();
    chk(32'(rq.size() - b), 32'h0000_0000);
    chk(32'(crs_n - c0), 32'h0000_0000);
    $display("test echo done");
    apb(REG_CTRL, 1'b1, 32'h0000_4100);
    f10();
    rxchk({5'h05, 5'h0d, 5'h0a});
    chk(32'(tq[tq.size() - 5]), 32'h0000_0000);
    apb(REG_CTRL, 1'b1, 32'h0000_1000);
    fdx <= 1'b0;
    spd <= 1'b1;
    per(50 * HALF_100);
    $display("test loopback done");
    repeat (6) mac.send(6'h00);
    b = tq.size();
    repeat (4) mac.send(6'h00);
    repeat (3) mac.send(6'h15);
    mac.send(6'h1d);
    mac.send(6'h33);
    mac.send(6'h17);
    repeat (8) mac.send(6'h00);
    for (i = b; i < b + 3; i++)
      void'(ks(tq[i] ^ 5'h1f, 1'b1));
    do begin
      p = tq[i] ^ ks(5'h00, 1'b0);
      i++;
    end while (p === 5'h1f && i < b + 12);
    chk(32'(p), 32'h0000_0018);
    txchk({5'h11, 5'h0b, 5'h1b, 5'h04, 5'h0f, 5'h0d,
      5'h07, 5'h1f});
    $display("test transmit done");
    b = rq.size();
    c0 = col_n;
    fork
      line({5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h18, 5'h11,
        5'h16, 5'h15, 5'h00, 5'h0e, 5'h0d, 5'h07, 5'h1f, 5'h1f});
      begin
        repeat (60) @(posedge pclk);
        repeat (40) mac.send(6'h15);
        repeat (4) mac.send(6'h00);
      end
    join
    rxchk({5'h05, 5'h0a, 5'h03, 5'h15, 5'h06});
    chk(32'(col_n - c0 > 24), 32'h0000_0001);
    chk(32'(rx_dv), 32'h0000_0000);
    @(negedge pclk);
    chk(32'(rx_clk), 32'(tx_clk));
    $display("test receive done");
    end_sim();
  end
endmodule
`default_nettype wire
